// [verilog/motion_sel_pkg.sv]
// package: constants and carrier types of the motion command select block
// assumes: included before all other design files
package motion_sel_pkg;
  localparam int GEAR_W = 23;
  localparam int RATIO_W = 14;
  localparam int SPEED_W = 16;
  localparam int PCT_W = 8;
  localparam int MCODE_W = 8;
  localparam logic [PCT_W-1:0] OVR_WEIGHT_A_DEF = 8'h0a;
  localparam logic [PCT_W-1:0] OVR_WEIGHT_B_DEF = 8'h14;
  localparam logic [PCT_W-1:0] OVR_WEIGHT_C_DEF = 8'h28;
  localparam logic [PCT_W-1:0] OVR_WEIGHT_D_DEF = 8'h50;
  localparam logic [GEAR_W-1:0] GEAR_NUM_DEF = 23'h000001;
  localparam logic [GEAR_W-1:0] GEAR_NUM_MAX = 23'h400000;
  localparam logic [RATIO_W-1:0] PULSE_RATIO_1_DEF = 14'h0064;
  localparam logic [RATIO_W-1:0] PULSE_RATIO_2_DEF = 14'h03e8;
  localparam logic [RATIO_W-1:0] PULSE_RATIO_MIN = 14'h0001;
  localparam logic [RATIO_W-1:0] PULSE_RATIO_MAX = 14'h2710;
  localparam logic [RATIO_W-1:0] PULSE_RATIO_UNITY = 14'h0064;
  localparam logic [3:0] MODE_EXTENDED = 4'h6;
  localparam logic [3:0] MODE_POSITIONING = 4'h7;
  localparam logic [MCODE_W-1:0] MCODE_IDLE_LOW = 8'h00;
  localparam logic [MCODE_W-1:0] MCODE_IDLE_HIGH = 8'hff;
  localparam logic MCODE_IDLE_DEF = 1'b1;
  localparam logic [9:0] SPEED_PCT_FULL = 10'h064;
  localparam int CLK_HZ = 100000000;
  localparam int TICK_10MS_CYC = CLK_HZ / 100;
  localparam int TICK_1MS_CYC = CLK_HZ / 1000;

  typedef enum logic [1:0] {
    NOADDR_NONE = 2'h0,
    NOADDR_SEQ_START = 2'h1,
    NOADDR_HOMING = 2'h2,
    NOADDR_IMMEDIATE = 2'h3
  } no_address_action_t;

  typedef enum logic [3:0] {
    CTRL_POSITION = 4'h0,
    CTRL_SPEED = 4'h1,
    CTRL_TORQUE = 4'h2,
    CTRL_OTHER = 4'hf
  } control_kind_t;

  typedef enum logic [2:0] {
    ACT_IDLE = 3'h0,
    ACT_DATA = 3'h1,
    ACT_SEQ = 3'h2,
    ACT_HOME = 3'h3,
    ACT_IMM = 3'h4
  } start_action_t;

  // restart-only settings
  typedef struct packed {
    logic positioning_source_select;
    no_address_action_t no_address_action_select;
    logic mcode_idle_level;
    logic reversal_condition_select;
    logic torque_mode_speed_limit_source;
  } restart_cfg_t;

  typedef struct packed {
    logic command_complete;
    logic deviation_in_zero_range;
    logic speed_in_zero_range;
    logic direction_reversed;
    logic chaining;
  } chain_status_t;
endpackage : motion_sel_pkg

// [verilog/standstill_tick.sv]
// standstill timer tick generator
// assumes: 100 MHz ref_clk, synchronous active low nrst
`timescale 1ns/1ns
`default_nettype none
module standstill_tick #(
  parameter int CYC_COARSE = motion_sel_pkg::TICK_10MS_CYC,
  parameter int CYC_FINE = motion_sel_pkg::TICK_1MS_CYC
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic fine_sel,
  output logic tick
);
  logic [23:0] cnt_reg;
  logic [23:0] cnt_next;
  logic [23:0] limit;
  logic tick_next;
  logic tick_reg;

  always_comb begin
    limit = fine_sel ? 24'(CYC_FINE - 1) : 24'(CYC_COARSE - 1);
    tick_next = 1'b0;
    if (cnt_reg >= limit) begin
      cnt_next = 24'h000000;
      tick_next = 1'b1;
    end else begin
      cnt_next = cnt_reg + 24'h000001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      cnt_reg <= 24'h000000;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;
endmodule : standstill_tick
`default_nettype wire

// [verilog/speed_limit_table.sv]
// table of eight torque-mode speed limits with registered read
// assumes: write port driven by parameter software
`timescale 1ns/1ns
`default_nettype none
module speed_limit_table #(
  parameter int WIDTH = motion_sel_pkg::SPEED_W
) (
  input wire logic ref_clk,
  input wire logic wr_en,
  input wire logic [2:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [2:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [0:7];
  logic [WIDTH-1:0] rd_reg;

  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_reg <= mem[rd_addr];
  end

  assign rd_data = rd_reg;
endmodule : speed_limit_table
`default_nettype wire

// [verilog/servo_motion_command_select.sv]
// motion command selection and scaling of a servo drive
// assumes: discrete inputs synchronous to ref_clk, settings static ports
`timescale 1ns/1ns
`default_nettype none
module servo_motion_command_select #(
  parameter int GEAR_W = motion_sel_pkg::GEAR_W,
  parameter int RATIO_W = motion_sel_pkg::RATIO_W,
  parameter int SPEED_W = motion_sel_pkg::SPEED_W,
  parameter int TICK_COARSE_CYC = motion_sel_pkg::TICK_10MS_CYC,
  parameter int TICK_FINE_CYC = motion_sel_pkg::TICK_1MS_CYC
) (
  input wire logic ref_clk,
  input wire logic nrst,
  // override
  input wire logic override_enable,
  input wire logic [3:0] override_inputs,
  input wire logic [7:0] override_weight_a,
  input wire logic [7:0] override_weight_b,
  input wire logic [7:0] override_weight_c,
  input wire logic [7:0] override_weight_d,
  input wire motion_sel_pkg::control_kind_t control_kind,
  output logic [9:0] traveling_speed_pct,
  // start selection
  input wire motion_sel_pkg::restart_cfg_t restart_cfg,
  input wire logic [3:0] point_address,
  input wire logic start_request,
  output motion_sel_pkg::start_action_t start_action,
  output logic [3:0] start_point,
  // standstill timer
  input wire logic standstill_timer_resolution,
  output logic standstill_tick_out,
  // mcode
  input wire logic mcode_on,
  input wire logic [7:0] mcode_value,
  output logic [7:0] mcode_out,
  // chaining
  input wire motion_sel_pkg::chain_status_t chain_status,
  input wire logic in_position_raw,
  output logic next_motion_start,
  output logic in_position_output,
  // gear
  input wire logic [1:0] gear_select,
  input wire logic [GEAR_W-1:0] gear_numerator_0,
  input wire logic [GEAR_W-1:0] gear_numerator_1,
  input wire logic [GEAR_W-1:0] gear_numerator_2,
  input wire logic [GEAR_W-1:0] gear_numerator_3,
  input wire logic [GEAR_W-1:0] gear_denominator,
  output logic [GEAR_W-1:0] gear_numerator_out,
  output logic [GEAR_W-1:0] gear_denominator_out,
  // pulse ratio
  input wire logic pulse_ratio_select,
  input wire logic [RATIO_W-1:0] pulse_ratio_1,
  input wire logic [RATIO_W-1:0] pulse_ratio_2,
  input wire logic [3:0] control_mode_select,
  output logic [RATIO_W-1:0] pulse_ratio_out,
  // speed limit
  input wire logic [2:0] speed_select,
  input wire logic [SPEED_W-1:0] max_rotation_speed,
  input wire logic [SPEED_W-1:0] analog_speed_ref,
  input wire logic limit_wr_en,
  input wire logic [2:0] limit_wr_addr,
  input wire logic [SPEED_W-1:0] limit_wr_data,
  output logic [SPEED_W-1:0] speed_limit_out
);
  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  function automatic logic [RATIO_W-1:0] clamp_ratio(input logic [RATIO_W-1:0] r);
    if (r < motion_sel_pkg::PULSE_RATIO_MIN) begin
      clamp_ratio = motion_sel_pkg::PULSE_RATIO_MIN;
    end else if (r > motion_sel_pkg::PULSE_RATIO_MAX) begin
      clamp_ratio = motion_sel_pkg::PULSE_RATIO_MAX;
    end else begin
      clamp_ratio = r;
    end
  endfunction : clamp_ratio

  function automatic logic [GEAR_W-1:0] clamp_gear(input logic [GEAR_W-1:0] g);
    if (g == '0) begin
      clamp_gear = motion_sel_pkg::GEAR_NUM_DEF;
    end else if (g > motion_sel_pkg::GEAR_NUM_MAX) begin
      clamp_gear = motion_sel_pkg::GEAR_NUM_MAX;
    end else begin
      clamp_gear = g;
    end
  endfunction : clamp_gear

  // ---------------------------------------------
  // restart-only settings
  // ---------------------------------------------
  motion_sel_pkg::restart_cfg_t cfg_reg;
  motion_sel_pkg::restart_cfg_t cfg_next;
  logic cfg_loaded_reg;
  logic cfg_loaded_next;

  always_comb begin
    cfg_next = cfg_reg;
    cfg_loaded_next = 1'b1;
    if (!cfg_loaded_reg) begin
      cfg_next = restart_cfg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      cfg_reg <= '{1'b0, motion_sel_pkg::NOADDR_NONE, motion_sel_pkg::MCODE_IDLE_DEF, 1'b0, 1'b0};
      cfg_loaded_reg <= 1'b0;
    end else begin
      cfg_reg <= cfg_next;
      cfg_loaded_reg <= cfg_loaded_next;
    end
  end

  // ---------------------------------------------
  // override and traveling speed
  // ---------------------------------------------
  logic [9:0] speed_next;
  logic [9:0] speed_reg;

  always_comb begin
    speed_next = motion_sel_pkg::SPEED_PCT_FULL;
    if (override_enable && control_kind != motion_sel_pkg::CTRL_TORQUE && control_kind != motion_sel_pkg::CTRL_OTHER) begin
      speed_next = (override_inputs[0] ? {2'h0, override_weight_a} : 10'h000)
                 + (override_inputs[1] ? {2'h0, override_weight_b} : 10'h000)
                 + (override_inputs[2] ? {2'h0, override_weight_c} : 10'h000)
                 + (override_inputs[3] ? {2'h0, override_weight_d} : 10'h000);
    end
  end

  // ---------------------------------------------
  // start action selection
  // ---------------------------------------------
  motion_sel_pkg::start_action_t act_next;
  motion_sel_pkg::start_action_t act_reg;
  logic [3:0] point_next;
  logic [3:0] point_reg;

  always_comb begin
    act_next = motion_sel_pkg::ACT_IDLE;
    point_next = point_reg;
    if (start_request) begin
      if (point_address != 4'h0) begin
        act_next = cfg_reg.positioning_source_select ? motion_sel_pkg::ACT_DATA : motion_sel_pkg::ACT_IMM;
        point_next = point_address;
      end else begin
        case (cfg_reg.no_address_action_select)
          motion_sel_pkg::NOADDR_SEQ_START: act_next = motion_sel_pkg::ACT_SEQ;
          motion_sel_pkg::NOADDR_HOMING: act_next = motion_sel_pkg::ACT_HOME;
          motion_sel_pkg::NOADDR_IMMEDIATE: act_next = motion_sel_pkg::ACT_IMM;
          default: act_next = cfg_reg.positioning_source_select ? motion_sel_pkg::ACT_DATA : motion_sel_pkg::ACT_IMM;
        endcase
        point_next = 4'h0;
      end
    end
  end

  // ---------------------------------------------
  // chaining and in-position
  // ---------------------------------------------
  logic next_next;
  logic next_reg;
  logic inp_next;
  logic inp_reg;

  always_comb begin
    if (chain_status.chaining && chain_status.direction_reversed && cfg_reg.reversal_condition_select) begin
      next_next = chain_status.command_complete && chain_status.deviation_in_zero_range
                  && chain_status.speed_in_zero_range;
    end else begin
      next_next = chain_status.command_complete;
    end
    inp_next = in_position_raw && !chain_status.chaining;
  end

  // ---------------------------------------------
  // gear, pulse ratio, mcode, speed limit
  // ---------------------------------------------
  logic [GEAR_W-1:0] gear_next;
  logic [GEAR_W-1:0] gear_reg;
  logic [GEAR_W-1:0] den_reg;
  logic [GEAR_W-1:0] den_next;
  logic [RATIO_W-1:0] ratio_next;
  logic [RATIO_W-1:0] ratio_reg;
  logic [7:0] mcode_next;
  logic [7:0] mcode_reg;
  logic [SPEED_W-1:0] limit_next;
  logic [SPEED_W-1:0] limit_reg;
  logic [SPEED_W-1:0] table_data;
  logic [2:0] sel_d_reg;

  always_comb begin
    case (gear_select)
      2'h1: gear_next = clamp_gear(gear_numerator_1);
      2'h2: gear_next = clamp_gear(gear_numerator_2);
      2'h3: gear_next = clamp_gear(gear_numerator_3);
      default: gear_next = clamp_gear(gear_numerator_0);
    endcase
    den_next = clamp_gear(gear_denominator);
    ratio_next = motion_sel_pkg::PULSE_RATIO_UNITY;
    if (control_mode_select == motion_sel_pkg::MODE_EXTENDED
        || control_mode_select == motion_sel_pkg::MODE_POSITIONING) begin
      ratio_next = clamp_ratio(pulse_ratio_select ? pulse_ratio_2 : pulse_ratio_1);
    end
    if (mcode_on) begin
      mcode_next = mcode_value;
    end else begin
      mcode_next = cfg_reg.mcode_idle_level ? motion_sel_pkg::MCODE_IDLE_HIGH : motion_sel_pkg::MCODE_IDLE_LOW;
    end
    if (!cfg_reg.torque_mode_speed_limit_source) begin
      limit_next = max_rotation_speed;
    end else if (sel_d_reg == 3'h0) begin
      limit_next = analog_speed_ref;
    end else begin
      limit_next = table_data;
    end
  end

  speed_limit_table #(
    .WIDTH(SPEED_W)
  ) u_limit_table (
    .ref_clk(ref_clk),
    .wr_en(limit_wr_en),
    .wr_addr(limit_wr_addr),
    .wr_data(limit_wr_data),
    .rd_addr(speed_select),
    .rd_data(table_data)
  );

  standstill_tick #(
    .CYC_COARSE(TICK_COARSE_CYC),
    .CYC_FINE(TICK_FINE_CYC)
  ) u_tick (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .fine_sel(standstill_timer_resolution),
    .tick(standstill_tick_out)
  );

  // ---------------------------------------------
  // output registers
  // ---------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      speed_reg <= motion_sel_pkg::SPEED_PCT_FULL;
      act_reg <= motion_sel_pkg::ACT_IDLE;
      point_reg <= 4'h0;
      next_reg <= 1'b0;
      inp_reg <= 1'b0;
      gear_reg <= motion_sel_pkg::GEAR_NUM_DEF;
      den_reg <= motion_sel_pkg::GEAR_NUM_DEF;
      ratio_reg <= motion_sel_pkg::PULSE_RATIO_UNITY;
      mcode_reg <= motion_sel_pkg::MCODE_IDLE_HIGH;
      limit_reg <= '0;
      sel_d_reg <= 3'h0;
    end else begin
      speed_reg <= speed_next;
      act_reg <= act_next;
      point_reg <= point_next;
      next_reg <= next_next;
      inp_reg <= inp_next;
      gear_reg <= gear_next;
      den_reg <= den_next;
      ratio_reg <= ratio_next;
      mcode_reg <= mcode_next;
      limit_reg <= limit_next;
      sel_d_reg <= speed_select;
    end
  end

  assign traveling_speed_pct = speed_reg;
  assign start_action = act_reg;
  assign start_point = point_reg;
  assign next_motion_start = next_reg;
  assign in_position_output = inp_reg;
  assign gear_numerator_out = gear_reg;
  assign gear_denominator_out = den_reg;
  assign pulse_ratio_out = ratio_reg;
  assign mcode_out = mcode_reg;
  assign speed_limit_out = limit_reg;
endmodule : servo_motion_command_select
`default_nettype wire

// [test/motion_sel_sva.sv]
// checker: port assertions of the motion select block
// assumes: bound to servo_motion_command_select, one clock
`timescale 1ns/1ns
`default_nettype none
module motion_sel_sva #(
  parameter int RATIO_W = 14
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic override_enable,
  input wire logic [3:0] override_inputs,
  input wire logic [7:0] override_weight_a,
  input wire logic [7:0] override_weight_b,
  input wire logic [7:0] override_weight_c,
  input wire logic [7:0] override_weight_d,
  input wire motion_sel_pkg::control_kind_t control_kind,
  input wire logic [9:0] traveling_speed_pct,
  input wire motion_sel_pkg::restart_cfg_t restart_cfg,
  input wire logic mcode_on,
  input wire logic [7:0] mcode_out,
  input wire motion_sel_pkg::chain_status_t chain_status,
  input wire logic next_motion_start,
  input wire logic in_position_output,
  input wire logic pulse_ratio_select,
  input wire logic [RATIO_W-1:0] pulse_ratio_1,
  input wire logic [RATIO_W-1:0] pulse_ratio_2,
  input wire logic [3:0] control_mode_select,
  input wire logic [RATIO_W-1:0] pulse_ratio_out
);
  // ------------
  // helper logic
  // ------------
  logic armed_reg;
  motion_sel_pkg::restart_cfg_t cfg_reg;
  logic [9:0] sum_w;
  logic [RATIO_W-1:0] rat_w;
  logic pos_spd;
  logic ext_mode;
  assign sum_w = (override_inputs[0] ? {2'h0, override_weight_a} : 10'h000)
    + (override_inputs[1] ? {2'h0, override_weight_b} : 10'h000)
    + (override_inputs[2] ? {2'h0, override_weight_c} : 10'h000)
    + (override_inputs[3] ? {2'h0, override_weight_d} : 10'h000);
  assign rat_w = pulse_ratio_select ? pulse_ratio_2 : pulse_ratio_1;
  assign pos_spd = control_kind == motion_sel_pkg::CTRL_POSITION || control_kind == motion_sel_pkg::CTRL_SPEED;
  assign ext_mode = control_mode_select == motion_sel_pkg::MODE_EXTENDED
    || control_mode_select == motion_sel_pkg::MODE_POSITIONING;
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      armed_reg <= 1'b1;
    end else if (armed_reg) begin
      armed_reg <= 1'b0;
      cfg_reg <= restart_cfg;
    end
  end
  // ----------
  // assertions
  // ----------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  ovr_sum_a: assert property (override_enable && pos_spd |=> traveling_speed_pct == $past(sum_w))
    else $error("override sum wrong");
  ovr_off_a: assert property (!override_enable |=> traveling_speed_pct == 10'h064)
    else $error("override not bypassed");
  torque_ovr_a: assert property (control_kind == motion_sel_pkg::CTRL_TORQUE |=> traveling_speed_pct == 10'h064)
    else $error("override in torque control");
  other_ovr_a: assert property (control_kind == motion_sel_pkg::CTRL_OTHER |=> traveling_speed_pct == 10'h064)
    else $error("override in other control");
  ratio_sel_a: assert property (ext_mode && rat_w != 0 && rat_w <= motion_sel_pkg::PULSE_RATIO_MAX
    |=> pulse_ratio_out == $past(rat_w)) else $error("pulse ratio select wrong");
  ratio_off_a: assert property (!ext_mode |=> pulse_ratio_out == motion_sel_pkg::PULSE_RATIO_UNITY)
    else $error("pulse ratio outside modes");
  mcode_idle_a: assert property (!armed_reg && !mcode_on |=> mcode_out == {8{cfg_reg.mcode_idle_level}})
    else $error("mcode idle level wrong");
  inpos_chain_a: assert property (chain_status.chaining |=> !in_position_output)
    else $error("in-position during chaining");
  chain_cmd_a: assert property (!armed_reg && !cfg_reg.reversal_condition_select
    |=> next_motion_start == $past(chain_status.command_complete)) else $error("chain start wrong");
  fb_gate_a: assert property (!armed_reg && cfg_reg.reversal_condition_select && chain_status.chaining
    && chain_status.direction_reversed |=> next_motion_start == $past(chain_status.command_complete
    && chain_status.deviation_in_zero_range && chain_status.speed_in_zero_range)) else $error("feedback gate wrong");
endmodule : motion_sel_sva
bind servo_motion_command_select motion_sel_sva #(.RATIO_W(RATIO_W)) u_motion_sel_sva (.*);
`default_nettype wire

// [test/host_ctrl_model.sv]
// partner: host controller driving override and gear inputs
// assumes: requests sampled at ref_clk rise, outputs change 1 ns later
`timescale 1ns/1ns
`default_nettype none
module host_ctrl_model (
  input wire logic ref_clk,
  input wire logic seq_busy,
  input wire logic ovr_en_req,
  input wire logic [3:0] ovr_req,
  input wire logic [1:0] gear_req,
  output logic override_enable,
  output logic [3:0] override_inputs,
  output logic [1:0] gear_select
);
  initial begin
    logic en_q;
    logic busy_q;
    logic [3:0] ovr_q;
    logic [1:0] gear_q;
    override_enable = 1'b0;
    override_inputs = 4'h0;
    gear_select = 2'h0;
    forever begin
      @(posedge ref_clk);
      en_q = ovr_en_req;
      busy_q = seq_busy;
      ovr_q = ovr_req;
      gear_q = gear_req;
      #1;
      override_enable = en_q;
      override_inputs = ovr_q;
      if (!busy_q) begin
        gear_select = gear_q;
      end
    end
  end
endmodule : host_ctrl_model
`default_nettype wire

// [test/tb_top.sv]
// testbench: directed scenarios for the motion select block
// assumes: host_ctrl_model drives override and gear inputs
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic ref_clk, nrst, seq_busy, ovr_en_req, override_enable, start_request;
  logic [3:0] ovr_req, override_inputs, point_address, start_point, control_mode_select;
  logic [1:0] gear_req, gear_select;
  logic [7:0] override_weight_a, override_weight_b, override_weight_c, override_weight_d, mcode_value, mcode_out;
  motion_sel_pkg::control_kind_t control_kind;
  logic [9:0] traveling_speed_pct;
  motion_sel_pkg::restart_cfg_t restart_cfg;
  motion_sel_pkg::start_action_t start_action;
  motion_sel_pkg::chain_status_t chain_status;
  logic standstill_timer_resolution, standstill_tick_out, mcode_on, in_position_raw;
  logic next_motion_start, in_position_output, pulse_ratio_select, limit_wr_en;
  logic [22:0] gear_numerator_0, gear_numerator_1, gear_numerator_2, gear_numerator_3;
  logic [22:0] gear_denominator, gear_numerator_out, gear_denominator_out;
  logic [13:0] pulse_ratio_1, pulse_ratio_2, pulse_ratio_out;
  logic [2:0] speed_select, limit_wr_addr;
  logic [15:0] max_rotation_speed, analog_speed_ref, limit_wr_data, speed_limit_out;
  logic [22:0] num_t [4] = '{23'h000011, 23'h000222, 23'h003333, 23'h400000};
  int miscompares = 0;
  int compares = 0;
  int cyc = 0;
  host_ctrl_model u_host_ctrl_model (.*);
  servo_motion_command_select #(.TICK_COARSE_CYC(10), .TICK_FINE_CYC(2)) u_servo_motion_command_select (.*);
  // -------
  // helpers
  // -------
  task step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : step
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task summarize;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize
  // ---------
  // scenarios
  // ---------
  task t_start(input logic [1:0] a);
    start_request = 1'b1;
    point_address = 4'h0;
    step(2);
    chk(start_action, {1'b0, a} + 3'h1);
    point_address = 4'h9;
    step(2);
    chk(start_action, a[1] ? motion_sel_pkg::ACT_IMM : motion_sel_pkg::ACT_DATA);
    chk(start_point, 4'h9);
    start_request = 1'b0;
    step(2);
    chk(start_action, motion_sel_pkg::ACT_IDLE);
    $display("start test done");
  endtask : t_start
  task t_mcode(input logic idle);
    mcode_on = 1'b1;
    mcode_value = 8'h5a;
    step(2);
    chk(mcode_out, 8'h5a);
    mcode_on = 1'b0;
    restart_cfg.mcode_idle_level = !idle;
    step(3);
    chk(mcode_out, {8{idle}});
    $display("mcode test done");
  endtask : t_mcode
  task t_chain(input logic rev);
    in_position_raw = 1'b1;
    chain_status = 5'h13;
    step(2);
    chk(next_motion_start, !rev);
    chk(in_position_output, 1'b0);
    chain_status = 5'h1f;
    step(2);
    chk(next_motion_start, 1'b1);
    chain_status = 5'h00;
    step(2);
    chk(in_position_output, 1'b1);
    $display("chain test done");
  endtask : t_chain
  task t_limit(input logic src);
    control_kind = motion_sel_pkg::CTRL_TORQUE;
    limit_wr_en = 1'b1;
    step(1);
    limit_wr_en = 1'b0;
    speed_select = 3'h7;
    step(3);
    chk(speed_limit_out, src ? 16'h1234 : 16'h0bb8);
    speed_select = 3'h0;
    step(3);
    chk(speed_limit_out, src ? 16'h0456 : 16'h0bb8);
    $display("limit test done");
  endtask : t_limit
  task t_override;
    control_kind = motion_sel_pkg::CTRL_POSITION;
    ovr_en_req = 1'b1;
    for (int i = 0; i < 16; i++) begin
      ovr_req = i[3:0];
      control_kind = i[0] ? motion_sel_pkg::CTRL_SPEED : motion_sel_pkg::CTRL_POSITION;
      step(3);
      chk(traveling_speed_pct, (i[0] ? 10'h00a : 10'h000) + (i[1] ? 10'h014 : 10'h000)
        + (i[2] ? 10'h028 : 10'h000) + (i[3] ? 10'h050 : 10'h000));
    end
    ovr_en_req = 1'b0;
    step(3);
    chk(traveling_speed_pct, 10'h064);
    ovr_en_req = 1'b1;
    control_kind = motion_sel_pkg::CTRL_TORQUE;
    step(3);
    chk(traveling_speed_pct, 10'h064);
    control_kind = motion_sel_pkg::CTRL_OTHER;
    step(3);
    chk(traveling_speed_pct, motion_sel_pkg::SPEED_PCT_FULL);
    $display("override test done");
  endtask : t_override
  task t_gear;
    for (int i = 0; i < 4; i++) begin
      gear_req = i[1:0];
      step(3);
      chk(gear_numerator_out, num_t[i]);
    end
    chk(gear_denominator_out, 23'h000007);
    seq_busy = 1'b1;
    gear_req = 2'h0;
    step(3);
    chk(gear_numerator_out, num_t[3]);
    seq_busy = 1'b0;
    $display("gear test done");
  endtask : t_gear
  task t_ratio;
    for (int i = 0; i < 4; i++) begin
      control_mode_select = i[1] ? 4'h7 : 4'h6;
      pulse_ratio_select = i[0];
      step(2);
      chk(pulse_ratio_out, i[0] ? 14'h2710 : 14'h0001);
    end
    control_mode_select = 4'h0;
    step(2);
    chk(pulse_ratio_out, 14'h0064);
    $display("ratio test done");
  endtask : t_ratio
  task t_tick(input logic res, input int n);
    int k;
    standstill_timer_resolution = res;
    step(n + 2);
    k = 0;
    repeat (10 * n) begin
      if (standstill_tick_out === 1'b1) k++;
      step(1);
    end
    chk(k, 10);
    $display("tick test done");
  endtask : t_tick
  // ----
  // main
  // ----
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      summarize;
    end
  end
  initial begin
    logic [1:0] a;
    {nrst, seq_busy, ovr_en_req, start_request, mcode_on, in_position_raw} = 6'h00;
    {ovr_req, point_address, gear_req, speed_select} = 13'h0000;
    override_weight_a = motion_sel_pkg::OVR_WEIGHT_A_DEF;
    override_weight_b = motion_sel_pkg::OVR_WEIGHT_B_DEF;
    override_weight_c = motion_sel_pkg::OVR_WEIGHT_C_DEF;
    override_weight_d = motion_sel_pkg::OVR_WEIGHT_D_DEF;
    control_kind = motion_sel_pkg::CTRL_POSITION;
    restart_cfg = 6'h34;
    chain_status = 5'h00;
    {standstill_timer_resolution, pulse_ratio_select, limit_wr_en} = 3'h0;
    {mcode_value, control_mode_select} = 12'h000;
    {gear_numerator_0, gear_numerator_1, gear_numerator_2, gear_numerator_3} = {num_t[0], num_t[1], num_t[2], num_t[3]};
    gear_denominator = 23'h000007;
    {pulse_ratio_1, pulse_ratio_2} = {14'h0001, 14'h2710};
    {max_rotation_speed, analog_speed_ref, limit_wr_data} = {16'h0bb8, 16'h0456, 16'h1234};
    limit_wr_addr = 3'h7;
    for (int i = 0; i < 4; i++) begin
      a = i[1:0];
      nrst = 1'b0;
      restart_cfg = {~a[1], a, a[0], a[1], a[1]};
      step(10);
      nrst = 1'b1;
      step(2);
      t_start(a);
      t_mcode(a[0]);
      t_chain(a[1]);
      t_limit(a[1]);
    end
    t_override;
    t_gear;
    t_ratio;
    t_tick(1'b0, 10);
    t_tick(1'b1, 2);
    summarize;
  end
endmodule : tb_top
`default_nettype wire
